// ==== rtl/mimt_gptimer.v ====
/*
 * General-purpose down timer counting rising edges of the PHY transmit clock.
 * Assumes phy_tx_clk is far slower than clk; it is synchronised here.
 */
`timescale 1ns/1ps
module mimt_gptimer #(
  parameter W = 16
) (
  // Clock and reset
  input  wire         clk,
  input  wire         sys_rst,
  // PHY transmit clock pin
  input  wire         phy_tx_clk,
  // Control
  input  wire         load,
  input  wire [W-1:0] load_val,
  input  wire         continuous,
  // State
  output reg  [W-1:0] count_q,
  output reg          expired_q
);

  reg         sync1_q;
  reg         sync2_q;
  reg         sync3_q;
  reg [W-1:0] reload_q;
  reg         run_q;
  wire        bit_tick = sync2_q & ~sync3_q;
  wire [W-1:0] one    = {{(W-1){1'b0}}, 1'b1};

  // ********************************************
  // Transmit clock synchroniser and edge
  // ********************************************
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= phy_tx_clk;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // ********************************************
  // Down counter
  // ********************************************
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reload_q  <= {W{1'b0}};
      count_q   <= {W{1'b0}};
      run_q     <= 1'b0;
      expired_q <= 1'b0;
    end else begin
      expired_q <= 1'b0;
      if (load) begin
        reload_q <= load_val;
        count_q  <= load_val;
        run_q    <= (load_val != {W{1'b0}});
      end else if (run_q && bit_tick) begin
        if (count_q == one) begin
          expired_q <= 1'b1;
          if (continuous) begin
            count_q <= reload_q;
          end else begin
            count_q <= {W{1'b0}};
            run_q   <= 1'b0;
          end
        end else begin
          count_q <= count_q - one;
        end
      end
    end
  end

endmodule

// ==== rtl/mimt_mitig.v ====
/*
 * One completion-interrupt mitigation unit: frame counter and timer.
 * Assumes frame_ok and tick are one-cycle pulses on clk.
 */
`timescale 1ns/1ps
module mimt_mitig #(
  parameter W = 4
) (
  // Clock and reset
  input  wire         clk,
  input  wire         sys_rst,
  // Settings
  input  wire [W-1:0] frames_cfg,
  input  wire [W-1:0] timer_cfg,
  // Events
  input  wire         frame_ok,
  input  wire         tick,
  output reg          fire_q
);

  reg  [W-1:0] cnt_q;
  reg  [W-1:0] cnt_d;
  reg  [W-1:0] tmr_q;
  reg  [W-1:0] tmr_d;
  reg          run_q;
  reg          run_d;
  reg          fire_d;
  wire [W-1:0] cnt_eff = (cnt_q == {W{1'b0}}) ? frames_cfg : cnt_q;
  wire         off     = (frames_cfg == {W{1'b0}}) && (timer_cfg == {W{1'b0}});

  // ********************************************
  // Counter and timer
  // ********************************************
  always @* begin
    cnt_d  = cnt_q;
    tmr_d  = tmr_q;
    run_d  = run_q;
    fire_d = 1'b0;
    if (run_q && tick) begin
      tmr_d = tmr_q - {{(W-1){1'b0}}, 1'b1};
      if (tmr_q == {{(W-1){1'b0}}, 1'b1})
        fire_d = 1'b1;
    end
    if (frame_ok) begin
      if (frames_cfg != {W{1'b0}}) begin
        cnt_d = cnt_eff - {{(W-1){1'b0}}, 1'b1};
        if (cnt_eff == {{(W-1){1'b0}}, 1'b1})
          fire_d = 1'b1;
      end
      if (!run_q && timer_cfg != {W{1'b0}}) begin
        run_d = 1'b1;
        tmr_d = timer_cfg;
      end
      if (off)
        fire_d = 1'b1;
    end
    if (fire_d) begin
      cnt_d = frames_cfg;
      tmr_d = timer_cfg;
      run_d = 1'b0;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q  <= {W{1'b0}};
      tmr_q  <= {W{1'b0}};
      run_q  <= 1'b0;
      fire_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tmr_q  <= tmr_d;
      run_q  <= run_d;
      fire_q <= fire_d;
    end
  end

endmodule

// ==== rtl/mimt_top.v ====
/*
 * MAC interrupt controller with transmit/receive mitigation and a
 * general-purpose timer, reached over APB.
 * Assumes event inputs are one-cycle pulses from logic on clk, and the
 * PHY transmit clock arrives as a raw pin.
 */
// Implementation choices: the address map and the APB slave port.
//
// Operation
// - Ten status bits can raise an interrupt, split into a normal and an abnormal group.
// - Each group has a summary flag and the two flags set the interrupt output level.
// - Each source has an enable bit and a disabled source adds nothing to its summary.
// - Transmit and receive each have a mitigation unit with a 4-bit frame counter and 4-bit timer.
// - A good frame decrements its unit's counter and starts its timer if not already running.
// - A unit fires its completion interrupt when counter or timer reaches zero, first one wins.
// - A transmitted frame flagged for completion interrupt sets the transmit interrupt at once.
// - Each status register write drives the interrupt output low for exactly one cycle.
// - A 16-bit general-purpose down timer counts PHY transmit clock edges.
// - In one-shot mode the timer stops at zero until reloaded.
// - In continuous mode the timer reloads on zero and keeps counting.
// - Reading the low 16 bits of the mitigation/timer register gives the live timer count.
// - Writing those bits sets the reload value and restarts the timer from it.
// - Mitigation settings live in the same register as the timer.
//
`timescale 1ns/1ps
`include "mimt_defines.vh"
module mimt_top #(
  parameter        MIT_W         = 4,
  parameter        TMR_W         = 16,
  parameter [15:0] MIT_TICK_LAST = 16'h00ff
) (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Transmit events
  input  wire        tx_frame_ok,
  input  wire        irq_on_completion_flag,
  input  wire        tx_stopped_evt,
  input  wire        tx_nobuf_evt,
  input  wire        tx_jabber_evt,
  input  wire        tx_underrun_evt,
  // Receive events
  input  wire        rx_frame_ok,
  input  wire        rx_nobuf_evt,
  input  wire        rx_stopped_evt,
  input  wire        rx_watchdog_evt,
  // PHY transmit clock pin
  input  wire        phy_tx_clk,
  // Interrupt
  output reg         irq
);

  // ********************************************
  // Declarations
  // ********************************************
  reg  [`MIMT_NSRC-1:0] status_q;
  reg  [`MIMT_NSRC-1:0] enable_q;
  reg  [MIT_W-1:0]      tx_frames_q;
  reg  [MIT_W-1:0]      tx_timer_q;
  reg  [MIT_W-1:0]      rx_frames_q;
  reg  [MIT_W-1:0]      rx_timer_q;
  reg                   cont_q;
  reg  [15:0]           tick_cnt_q;
  reg                   tick_q;
  reg  [31:0]           rdata_d;
  reg                   hit_d;
  wire                  acc_first;
  wire                  acc_done;
  wire                  wr_done;
  wire                  wr_status;
  wire                  wr_enable;
  wire                  wr_mittmr;
  wire                  wr_ctrl;
  wire                  tx_fire;
  wire                  rx_fire;
  wire                  gp_expired;
  wire [TMR_W-1:0]      gp_count;
  wire [`MIMT_NSRC-1:0] evt;
  wire [`MIMT_NSRC-1:0] active;
  wire                  normal_group_summary;
  wire                  abnormal_group_summary;
  wire                  rd_capture;
  wire                  sel_status;
  wire                  sel_enable;
  wire                  sel_mittmr;
  wire                  sel_ctrl;
  wire                  tx_counted;
  wire                  tx_bypass;
  wire [`MIMT_NSRC-1:0] status_d;
  wire                  irq_d;

  // ********************************************
  // APB access phases
  // ********************************************
  assign acc_first  = psel & penable & ~pready;
  assign acc_done   = psel & penable & pready;
  assign rd_capture = acc_first & ~pwrite;
  assign wr_done    = acc_done & pwrite & hit_d;
  assign wr_status  = wr_done & sel_status;
  assign wr_enable  = wr_done & sel_enable;
  assign wr_mittmr  = wr_done & sel_mittmr;
  assign wr_ctrl    = wr_done & sel_ctrl;

  // ********************************************
  // Address decode
  // ********************************************
  assign sel_status = (paddr == `MIMT_OFS_STATUS);
  assign sel_enable = (paddr == `MIMT_OFS_ENABLE);
  assign sel_mittmr = (paddr == `MIMT_OFS_MITTMR);
  assign sel_ctrl   = (paddr == `MIMT_OFS_CTRL);

  // ********************************************
  // Read decode
  // ********************************************
  always @* begin
    rdata_d = `MIMT_RST_DATA;
    hit_d   = 1'b1;
    case (paddr)
      `MIMT_OFS_STATUS: begin
        rdata_d[`MIMT_NSRC-1:0]  = status_q;
        rdata_d[`MIMT_STAT_ABN]  = abnormal_group_summary;
        rdata_d[`MIMT_STAT_NORM] = normal_group_summary;
      end
      `MIMT_OFS_ENABLE: begin
        rdata_d[`MIMT_NSRC-1:0] = enable_q;
      end
      `MIMT_OFS_MITTMR: begin
        rdata_d[`MIMT_TMR_F] = gp_count;
        rdata_d[`MIMT_TXF_F] = tx_frames_q;
        rdata_d[`MIMT_TXT_F] = tx_timer_q;
        rdata_d[`MIMT_RXF_F] = rx_frames_q;
        rdata_d[`MIMT_RXT_F] = rx_timer_q;
      end
      `MIMT_OFS_CTRL: begin
        rdata_d[`MIMT_CTRL_CONT] = cont_q;
      end
      default: begin
        hit_d = 1'b0;
      end
    endcase
  end

  // ********************************************
  // APB answer, one wait state
  // ********************************************
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `MIMT_RST_DATA;
    end else begin
      pready  <= acc_first;
      pslverr <= acc_first & ~hit_d;
      if (rd_capture)
        prdata <= rdata_d;
    end
  end

  // ********************************************
  // Configuration registers
  // ********************************************
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable_q <= `MIMT_RST_ENABLE;
      tx_frames_q <= {MIT_W{1'b0}};
      tx_timer_q  <= {MIT_W{1'b0}};
      rx_frames_q <= {MIT_W{1'b0}};
      rx_timer_q  <= {MIT_W{1'b0}};
      cont_q   <= 1'b0;
    end else begin
      if (wr_enable)
        enable_q <= pwdata[`MIMT_NSRC-1:0];
      if (wr_mittmr) begin
        tx_frames_q <= pwdata[`MIMT_TXF_F];
        tx_timer_q  <= pwdata[`MIMT_TXT_F];
        rx_frames_q <= pwdata[`MIMT_RXF_F];
        rx_timer_q  <= pwdata[`MIMT_RXT_F];
      end
      if (wr_ctrl)
        cont_q <= pwdata[`MIMT_CTRL_CONT];
    end
  end

  // ********************************************
  // Mitigation time base
  // ********************************************
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_q <= `MIMT_RST_TICK;
      tick_q     <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == MIT_TICK_LAST);
      if (tick_cnt_q == MIT_TICK_LAST)
        tick_cnt_q <= `MIMT_RST_TICK;
      else
        tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end

  // ********************************************
  // Transmit frame split, counted or bypassed
  // ********************************************
  assign tx_counted = tx_frame_ok & ~irq_on_completion_flag;
  assign tx_bypass  = tx_frame_ok & irq_on_completion_flag;

  // ********************************************
  // Mitigation units
  // ********************************************
  mimt_mitig #(
    .W          (MIT_W)
  ) u_tx_mitig (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .frames_cfg (tx_frames_q),
    .timer_cfg  (tx_timer_q),
    .frame_ok   (tx_counted),
    .tick       (tick_q),
    .fire_q     (tx_fire)
  );

  mimt_mitig #(
    .W          (MIT_W)
  ) u_rx_mitig (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .frames_cfg (rx_frames_q),
    .timer_cfg  (rx_timer_q),
    .frame_ok   (rx_frame_ok),
    .tick       (tick_q),
    .fire_q     (rx_fire)
  );

  // ********************************************
  // General-purpose timer
  // ********************************************
  mimt_gptimer #(
    .W          (TMR_W)
  ) u_gptimer (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .phy_tx_clk (phy_tx_clk),
    .load       (wr_mittmr),
    .load_val   (pwdata[`MIMT_TMR_F]),
    .continuous (cont_q),
    .count_q    (gp_count),
    .expired_q  (gp_expired)
  );

  // ********************************************
  // Status sources
  // ********************************************
  assign evt[`MIMT_SRC_TX_DONE]     = tx_fire | tx_bypass;
  assign evt[`MIMT_SRC_TX_STOPPED]  = tx_stopped_evt;
  assign evt[`MIMT_SRC_TX_NOBUF]    = tx_nobuf_evt;
  assign evt[`MIMT_SRC_TX_JABBER]   = tx_jabber_evt;
  assign evt[`MIMT_SRC_TX_UNDERRUN] = tx_underrun_evt;
  assign evt[`MIMT_SRC_RX_DONE]     = rx_fire;
  assign evt[`MIMT_SRC_RX_NOBUF]    = rx_nobuf_evt;
  assign evt[`MIMT_SRC_RX_STOPPED]  = rx_stopped_evt;
  assign evt[`MIMT_SRC_RX_WATCHDOG] = rx_watchdog_evt;
  assign evt[`MIMT_SRC_GP_TIMER]    = gp_expired;

  // ********************************************
  // Sticky status bits, set wins over clear
  // ********************************************
  genvar i;
  generate
    for (i = 0; i < `MIMT_NSRC; i = i + 1) begin : g_stat
      assign status_d[i] = evt[i] | (status_q[i] & ~(wr_status & pwdata[i]));
    end
  endgenerate

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      status_q <= `MIMT_RST_STATUS;
    else
      status_q <= status_d;
  end

  // ********************************************
  // Group summaries and interrupt output
  // ********************************************
  assign active                 = status_q & enable_q;
  assign normal_group_summary   = |(active & `MIMT_NORMAL_SEL);
  assign abnormal_group_summary = |(active & ~`MIMT_NORMAL_SEL);

  assign irq_d = (normal_group_summary | abnormal_group_summary) & ~wr_status;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= irq_d;
  end

endmodule

// ==== shared/mimt_defines.vh ====
/*
 * Register map, field layout and reset values of the MAC interrupt and
 * mitigation timer block.
 * Assumes it is included by bare name from the design files under rtl/.
 */
`ifndef MIMT_DEFINES_VH
`define MIMT_DEFINES_VH

// ********************************************
// Register offsets (byte addresses)
// ********************************************
`define MIMT_ADDR_W      8
`define MIMT_OFS_STATUS  8'h00
`define MIMT_OFS_ENABLE  8'h04
`define MIMT_OFS_MITTMR  8'h08
`define MIMT_OFS_CTRL    8'h0c

// ********************************************
// Status sources
// ********************************************
`define MIMT_NSRC            10
`define MIMT_SRC_TX_DONE     0
`define MIMT_SRC_TX_STOPPED  1
`define MIMT_SRC_TX_NOBUF    2
`define MIMT_SRC_TX_JABBER   3
`define MIMT_SRC_TX_UNDERRUN 4
`define MIMT_SRC_RX_DONE     5
`define MIMT_SRC_RX_NOBUF    6
`define MIMT_SRC_RX_STOPPED  7
`define MIMT_SRC_RX_WATCHDOG 8
`define MIMT_SRC_GP_TIMER    9
`define MIMT_NORMAL_SEL      10'h225
`define MIMT_STAT_ABN        15
`define MIMT_STAT_NORM       16

// ********************************************
// Mitigation / timer register fields
// ********************************************
`define MIMT_TMR_F  15:0
`define MIMT_TXF_F  19:16
`define MIMT_TXT_F  23:20
`define MIMT_RXF_F  27:24
`define MIMT_RXT_F  31:28
`define MIMT_CTRL_CONT 0

// ********************************************
// Reset values
// ********************************************
`define MIMT_RST_STATUS 10'h000
`define MIMT_RST_ENABLE 10'h000
`define MIMT_RST_MIT    16'h0000
`define MIMT_RST_TICK   16'h0000
`define MIMT_RST_DATA   32'h0000_0000

`endif

// ==== verification/mimt_chk.sv ====
/* Assertions on the APB slave and interrupt pin of mimt_top.
   Assumes one clock domain and a bind to the top module. */
`timescale 1ns/1ps
module mimt_chk (
  // Clock and reset
  input wire        clk,
  input wire        sys_rst,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Interrupt
  input wire        irq
);
  // ****************
  // Properties
  // ****************
  wire rd_or_rst = (psel && penable && !pwrite) || sys_rst;
  wire st_wr     = psel && penable && pwrite && pready && paddr == 8'h00;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  wait_state_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("access not one wait state");
  ready_inside_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_err_a: assert property (pready && paddr > 8'h0c |-> pslverr)
    else $error("unmapped address accepted");
  mapped_ok_a: assert property (pready && paddr[1:0] == 2'b00 && paddr <= 8'h0c |-> !pslverr)
    else $error("mapped address refused");
  err_rdata_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read gave data");
  rdata_hold_a: assert property (!$stable(prdata) |-> $past(rd_or_rst))
    else $error("read data moved outside a read");
  stat_dip_a: assert property (st_wr |=> !irq)
    else $error("irq not low after status write");
  cover property (st_wr);
  cover property (pready && pslverr);
  cover property ($rose(irq));
endmodule
bind mimt_top mimt_chk u_chk (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// ==== verification/mimt_host_model.sv ====
/* Edge-sensitive interrupt receiver in the place of the host.
   Assumes irq is synchronous to clk. */
`timescale 1ns/1ps
module mimt_host_model (
  // Clock and reset
  input  wire    clk,
  input  wire    sys_rst,
  // Interrupt line
  input  wire    irq,
  // Events seen
  output integer edges
);
  reg irq_q;
  // A status write dip must give a fresh rising edge
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
      edges <= 0;
    end else begin
      irq_q <= irq;
      if (irq && !irq_q)
        edges <= edges + 1;
    end
  end
endmodule

// ==== verification/mimt_top_tb_top.sv ====
/* Self-checking bench for mimt_top with a status model.
   Assumes mimt_chk is bound and the host model watches irq. */
`timescale 1ns/1ps
`include "mimt_defines.vh"
module mimt_top_tb_top;
  localparam [7:0] ST = `MIMT_OFS_STATUS;
  localparam [7:0] EN = `MIMT_OFS_ENABLE;
  localparam [7:0] MT = `MIMT_OFS_MITTMR;
  localparam [7:0] CT = `MIMT_OFS_CTRL;
  reg         clk;
  reg         sys_rst;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        irq;
  reg         txf;
  reg         icf;
  reg         rxf;
  reg  [9:0]  ev;
  reg         phy_clk;
  integer     edges;
  integer     error_cnt;
  integer     total_checks;
  integer     cyc;
  integer     k;
  integer     j;
  reg  [9:0]  m_stat;
  reg  [9:0]  m_en;
  reg  [31:0] rd;
  reg  [31:0] w;

  mimt_top #(.MIT_TICK_LAST(16'h0003)) uut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_frame_ok(txf), .irq_on_completion_flag(icf), .tx_stopped_evt(ev[1]), .tx_nobuf_evt(ev[2]),
    .tx_jabber_evt(ev[3]), .tx_underrun_evt(ev[4]), .rx_frame_ok(rxf), .rx_nobuf_evt(ev[6]),
    .rx_stopped_evt(ev[7]), .rx_watchdog_evt(ev[8]), .phy_tx_clk(phy_clk), .irq(irq));
  mimt_host_model host (.clk(clk), .sys_rst(sys_rst), .irq(irq), .edges(edges));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    phy_clk = 1'b0;
    forever #20 phy_clk = ~phy_clk;
  end

  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  // APB transfer; read data lands in rd
  task acc(input wr, input [7:0] a, input [31:0] d, input xe);
    begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
        @(posedge clk);
      rd = prdata;
      chk(pslverr, xe);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask

  // Status read compared with the model
  task rs;
    begin
      acc(1'b0, ST, 32'h0, 1'b0);
      chk(rd, {15'h0, |(m_stat & m_en & `MIMT_NORMAL_SEL), |(m_stat & m_en & ~`MIMT_NORMAL_SEL), 5'h0, m_stat});
    end
  endtask

  task clr;
    begin
      acc(1'b1, ST, 32'h3ff, 1'b0);
      m_stat = 10'h0;
    end
  endtask

  // Source k pulse; 10 is a transmit frame without the bypass flag
  task pulse(input integer k);
    begin
      txf <= (k == 0 || k == 10);
      icf <= (k == 0);
      rxf <= (k == 5);
      if (k != 0 && k != 5 && k != 10)
        ev[k] <= 1'b1;
      @(posedge clk);
      txf <= 1'b0;
      icf <= 1'b0;
      rxf <= 1'b0;
      ev <= 10'h0;
      repeat (3) @(posedge clk);
    end
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt = error_cnt + 1;
      give_verdict;
    end
  end

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    txf = 1'b0;
    icf = 1'b0;
    rxf = 1'b0;
    ev = 10'h0;
    error_cnt = 0;
    total_checks = 0;
    cyc = 0;
    m_stat = 10'h0;
    m_en = 10'h0;
    w = $urandom(32'h6c7caadb);
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (k = 0; k < 4; k = k + 1) begin
      acc(1'b0, {k[5:0], 2'b00}, 32'h0, 1'b0);
      chk(rd, 32'h0);
    end
    acc(1'b0, 8'h10, 32'h0, 1'b1);
    acc(1'b1, CT, 32'h1, 1'b0);
    acc(1'b0, CT, 32'h0, 1'b0);
    chk(rd, 32'h1);
    $display("test reset done");
    for (k = 0; k < 9; k = k + 1) begin
      w = $urandom;
      m_en = w[9:0];
      acc(1'b1, EN, w, 1'b0);
      pulse(k);
      m_stat[k] = 1'b1;
      rs;
      chk(irq, |(m_stat & m_en));
      w = $urandom;
      acc(1'b1, ST, w, 1'b0);
      m_stat = m_stat & ~w[9:0];
    end
    $display("test sources done");
    m_en = 10'h3ff;
    acc(1'b1, EN, 32'h3ff, 1'b0);
    pulse(3);
    m_stat[3] = 1'b1;
    j = edges;
    acc(1'b1, ST, 32'h0, 1'b0);
    repeat (2) @(posedge clk);
    chk(edges - j, 1);
    clr;
    $display("test dip done");
    acc(1'b1, MT, 32'h0003_0000, 1'b0);
    acc(1'b0, MT, 32'h0, 1'b0);
    chk(rd, 32'h0003_0000);
    for (k = 0; k < 2; k = k + 1) begin
      pulse(10);
      pulse(10);
      rs;
      pulse(0);
      m_stat[0] = 1'b1;
      rs;
      clr;
      pulse(10);
      m_stat[0] = 1'b1;
      rs;
      clr;
    end
    acc(1'b1, MT, 32'hff00_0000, 1'b0);
    pulse(5);
    rs;
    repeat (70) @(posedge clk);
    m_stat[5] = 1'b1;
    rs;
    clr;
    repeat (80) @(posedge clk);
    rs;
    $display("test mitigation done");
    acc(1'b1, CT, 32'h0, 1'b0);
    acc(1'b1, MT, 32'd20, 1'b0);
    acc(1'b0, MT, 32'h0, 1'b0);
    chk(rd[15:0] >= 16'd19 && rd[15:0] <= 16'd20, 1);
    repeat (230) @(posedge clk);
    m_stat[9] = 1'b1;
    rs;
    repeat (100) @(posedge clk);
    acc(1'b0, MT, 32'h0, 1'b0);
    chk(rd, 32'h0);
    clr;
    acc(1'b1, CT, 32'h1, 1'b0);
    acc(1'b1, MT, 32'd5, 1'b0);
    repeat (130) @(posedge clk);
    m_stat[9] = 1'b1;
    rs;
    acc(1'b0, MT, 32'h0, 1'b0);
    w = rd;
    repeat (20) @(posedge clk);
    acc(1'b0, MT, 32'h0, 1'b0);
    chk((w[15:0] | rd[15:0]) != 0 && w[15:0] <= 5 && rd[15:0] <= 5, 1);
    $display("test timer done");
    give_verdict;
  end
endmodule
